// file: iob_checker.sv
/*
  Port checker of iob_top, bound in at the foot of this file.
  Assumes iob_pkg is compiled first and one core clock.
*/
`timescale 1ns/100ps
`default_nettype none
// ----
// port checker
// ----
module iob_chk #(
  parameter int N_CH   = 16,
  parameter int MS_CYC = 50000
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  // watched ports
  input wire iob_pkg::iob_reg_req_t reg_req,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  bus_pwr,
  input wire logic                  bus_err,
  input wire logic                  sup_present,
  input wire logic [N_CH-1:0]       ch_overcurrent,
  input wire logic [N_CH-1:0]       ch_out,
  input wire iob_pkg::iob_led_t     led,
  input wire logic [N_CH-1:0]       led_ch
);
  import iob_pkg::*;
  localparam int LO = 10 * MS_CYC;
  // slack covers the tick phase and the pin synchroniser
  localparam int HI = 11 * MS_CYC + 4;
  logic o0_q;
  logic trk_q;
  int   cnt_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // off time of output 0 after it drops under overcurrent
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o0_q  <= 1'b0;
      trk_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      o0_q <= ch_out[0];
      if (o0_q && !ch_out[0] && ch_overcurrent[0]) begin
        trk_q <= 1'b1;
        cnt_q <= 1;
      end else if (ch_out[0]) begin
        trk_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
  property p_bus_off; !bus_pwr |=> !led.bus_grn && !led.bus_red; endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus leds lit unpowered");
  property p_bus_err; bus_pwr && bus_err |=> !led.bus_grn && led.bus_red; endproperty
  a_bus_err: assert property (p_bus_err) else $error("bus error not shown");
  property p_bus_up; bus_pwr && !bus_err |=> led.bus_grn; endproperty
  a_bus_up: assert property (p_bus_up) else $error("bus green dark");
  property p_sup_off; !sup_present [*8] |-> !led.blk_grn && !led.blk_red; endproperty
  a_sup_off: assert property (p_sup_off) else $error("block leds lit");
  property p_led_out; 1 |=> (led_ch & $past(ch_out)) == $past(ch_out); endproperty
  a_led_out: assert property (p_led_out) else $error("driven output led dark");
  property p_rd_idle; !reg_req.rd |=> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rearm_lo; trk_q && ch_out[0] |-> cnt_q >= LO; endproperty
  a_rearm_lo: assert property (p_rearm_lo) else $error("output re-armed early");
  property p_rearm_hi; trk_q |-> cnt_q <= HI; endproperty
  a_rearm_hi: assert property (p_rearm_hi) else $error("output re-arm late");
  c_trip: cover property (trk_q && ch_out[0]);
  c_err: cover property (led.bus_red && !led.bus_grn);
  c_read: cover property (reg_req.rd);
endmodule : iob_chk
bind iob_top iob_chk #(.N_CH(N_CH), .MS_CYC(MS_CYC)) i_iob_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .bus_pwr(bus_pwr), .bus_err(bus_err), .sup_present(sup_present),
  .ch_overcurrent(ch_overcurrent), .ch_out(ch_out), .led(led), .led_ch(led_ch));
`default_nettype wire

// file: iob_debounce.sv
/*
  Per-channel software debounce with a filter time in whole milliseconds.
  Assumes inputs already synchronised to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iob_map.svh"

module iob_debounce #(
  parameter int N_CH = 16
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // control
  input  wire logic            ms_tick,
  input  wire logic [4:0]      filt_ms,
  // data
  input  wire logic [N_CH-1:0] raw,
  output var  logic [N_CH-1:0] state
);
  import iob_pkg::*;

  if (N_CH < 1 || N_CH > 16) begin : g_chk
    $error("iob_debounce: N_CH out of range");
  end

  typedef struct packed {
    logic [N_CH-1:0][4:0] cnt;
    logic [N_CH-1:0]      val;
  } iob_deb_st_t;

  iob_deb_st_t st_q, st_d;

  // a new level must stand for filt_ms ticks; the first tick may be partial
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < N_CH; i++) begin
      if (raw[i] == st_q.val[i]) begin
        st_d.cnt[i] = 5'h00;
      end else if (filt_ms == 5'h00) begin
        st_d.val[i] = raw[i];
      end else if (ms_tick) begin
        if (st_q.cnt[i] + 5'h01 >= filt_ms) begin
          st_d.val[i] = raw[i];
          st_d.cnt[i] = 5'h00;
        end else begin
          st_d.cnt[i] = st_q.cnt[i] + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign state = st_q.val;

endmodule : iob_debounce
`default_nettype wire

// file: iob_flash.sv
/*
  Flash pattern generator: single flash, double flash and continuous blink.
  Assumes a one-cycle millisecond tick on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iob_map.svh"

module iob_flash #(
  parameter int SLOT_MS = `IOB_FLASH_MS
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // time base
  input  wire logic                ms_tick,
  // patterns
  output var  iob_pkg::iob_flash_t pat
);
  import iob_pkg::*;

  if (SLOT_MS < 2 || SLOT_MS > 255) begin : g_chk
    $error("iob_flash: SLOT_MS out of range");
  end

  typedef struct packed {
    logic [7:0]  ms;
    logic [2:0]  slot;
    iob_flash_t  pat;
  } iob_flash_st_t;

  iob_flash_st_t st_q, st_d;

  // a frame is eight slots; patterns light in fixed slots of it
  always_comb begin
    st_d = st_q;
    if (ms_tick) begin
      if (st_q.ms == 8'(SLOT_MS - 1)) begin
        st_d.ms   = 8'h00;
        st_d.slot = st_q.slot + 3'h1;
      end else begin
        st_d.ms = st_q.ms + 8'h01;
      end
    end
    st_d.pat.single = (st_q.slot == 3'h0);
    st_d.pat.dbl    = (st_q.slot == 3'h0) || (st_q.slot == 3'h2);
    st_d.pat.blink  = ~st_q.slot[0];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pat = st_q.pat;

endmodule : iob_flash
`default_nettype wire

// file: iob_map.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  I/O block status logic. Assumes a 50 MHz core clock and a 4-bit word index.
*/
`ifndef IOB_MAP_SVH
`define IOB_MAP_SVH

// ----------------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------------
`define IOB_A_ID        4'h0
`define IOB_A_CTRL      4'h1
`define IOB_A_DIR       4'h2
`define IOB_A_OUT       4'h3
`define IOB_A_IN        4'h4
`define IOB_A_FILT      4'h5
`define IOB_A_FAULT     4'h6
`define IOB_A_STAT      4'h7
`define IOB_A_TRIP      4'h8

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define IOB_CTRL_ERR    2
`define IOB_DW          16
`define IOB_RST_WORD    16'h0000
`define IOB_RST_FILT    5'h00
`define IOB_ID_DEFAULT  16'h5A31

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IOB_CLK_HZ      50000000
`define IOB_MS_CYC      (`IOB_CLK_HZ / 1000)
`define IOB_REARM_MS    10
`define IOB_FILT_MAX_MS 25
`define IOB_FLASH_MS    200
`define IOB_HW_FAST_US  10
`define IOB_HW_SLOW_US  70
`define IOB_HW_FAST_CYC ((`IOB_CLK_HZ / 1000000) * `IOB_HW_FAST_US)
`define IOB_HW_SLOW_CYC ((`IOB_CLK_HZ / 1000000) * `IOB_HW_SLOW_US)
`define IOB_SYNC_LAT    4

`endif

// file: iob_master.sv
/*
  Expansion-bus master model: register accesses and bus condition.
  Assumes the register port timing of iob_top.
*/
`timescale 1ns/100ps
`default_nettype none
// ----
// bus master model
// ----
module iob_master (
  // clock
  input  wire logic                  core_clk,
  // register port
  input  wire logic [15:0]           reg_rdata,
  output var  iob_pkg::iob_reg_req_t reg_req,
  // bus condition
  output var  logic                  bus_pwr,
  output var  logic                  bus_err
);
  import iob_pkg::*;
  initial begin
    reg_req = '0;
    bus_pwr = 1'b0;
    bus_err = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic bus(input logic p, input logic e);
    @(posedge core_clk);
    bus_pwr <= p;
    bus_err <= e;
  endtask : bus
endmodule : iob_master
`default_nettype wire

// file: iob_pkg.sv
/*
  Types shared by the I/O block status logic.
  Assumes iob_map.svh sits in the same folder.
*/
package iob_pkg;

  typedef enum logic [1:0] {
    IOB_BLK_RESET = 2'b00,
    IOB_BLK_PREOP = 2'b01,
    IOB_BLK_OPER  = 2'b10
  } iob_blk_st_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } iob_reg_req_t;

  typedef struct packed {
    logic bus_grn;
    logic bus_red;
    logic blk_grn;
    logic blk_red;
  } iob_led_t;

  typedef struct packed {
    logic single;
    logic dbl;
    logic blink;
  } iob_flash_t;

endpackage : iob_pkg

// file: iob_top.sv
/*
  Status indication and channel supervision of a 16-channel configurable
  digital I/O block: bus and block LEDs, channel LEDs, input debounce,
  output re-arm after overcurrent, identification word.
  Assumes bus_pwr and bus_err come from bus logic on core_clk, while
  channel, fault and supply pins arrive asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iob_map.svh"

module iob_top #(
  parameter int          N_CH     = 16,
  parameter int          MS_CYC   = `IOB_MS_CYC,
  parameter int          FLASH_MS = `IOB_FLASH_MS,
  // identification value is arbitrary
  parameter logic [15:0] ID_CODE  = `IOB_ID_DEFAULT
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // register port
  input  wire iob_pkg::iob_reg_req_t reg_req,
  output var  logic [15:0]           reg_rdata,
  // bus condition from bus logic
  input  wire logic                  bus_pwr,
  input  wire logic                  bus_err,
  // supply monitor pins
  input  wire logic                  sup_present,
  input  wire logic                  sup_in_range,
  // channel pins
  input  wire logic [N_CH-1:0]       ch_in,
  input  wire logic [N_CH-1:0]       ch_in_range_err,
  input  wire logic [N_CH-1:0]       ch_overcurrent,
  output var  logic [N_CH-1:0]       ch_out,
  // indicators
  output var  iob_pkg::iob_led_t     led,
  output var  logic [N_CH-1:0]       led_ch
);
  import iob_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (N_CH < 1 || N_CH > `IOB_DW) begin : g_chk_ch
    $error("iob_top: N_CH must be 1 to 16");
  end
  if (MS_CYC < 2 || MS_CYC > 65535) begin : g_chk_ms
    $error("iob_top: MS_CYC out of range");
  end
  // synchroniser delay stays under the fast and slow hardware filter limits
  if (`IOB_SYNC_LAT > `IOB_HW_FAST_CYC) begin : g_chk_fast
    $error("iob_top: input path too slow for channels 0 to 3");
  end
  if (`IOB_SYNC_LAT > `IOB_HW_SLOW_CYC) begin : g_chk_slow
    $error("iob_top: input path too slow for channels 4 up");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    // synchronisers: stage 1, 2, 3 and the accepted level
    logic [N_CH-1:0]      in_s1;
    logic [N_CH-1:0]      in_s2;
    logic [N_CH-1:0]      in_s3;
    logic [N_CH-1:0]      in_a;
    logic [N_CH-1:0]      rng_s1;
    logic [N_CH-1:0]      rng_s2;
    logic [N_CH-1:0]      rng_s3;
    logic [N_CH-1:0]      rng_a;
    logic [N_CH-1:0]      oc_s1;
    logic [N_CH-1:0]      oc_s2;
    logic [N_CH-1:0]      oc_s3;
    logic [N_CH-1:0]      oc_a;
    logic [1:0]           sup_s1;
    logic [1:0]           sup_s2;
    logic [1:0]           sup_s3;
    logic [1:0]           sup_a;
    // millisecond time base
    logic [15:0]          ms_cnt;
    logic                 ms_tick;
    // software registers
    iob_blk_st_t          blk_st;
    logic                 blk_err;
    logic [N_CH-1:0]      dir;
    logic [N_CH-1:0]      out_cmd;
    logic [4:0]           filt;
    logic [N_CH-1:0]      fault;
    // output protection
    logic [N_CH-1:0]      trip;
    logic [N_CH-1:0][3:0] rtmr;
    // registered outputs
    logic [N_CH-1:0]      ch_out;
    iob_led_t             led;
    logic [N_CH-1:0]      led_ch;
    logic [15:0]          rdata;
  } iob_top_st_t;

  iob_top_st_t     st_q, st_d;
  iob_flash_t      pat;
  logic [N_CH-1:0] in_deb;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] iob_word(input logic [N_CH-1:0] v);
    logic [15:0] w;
    w = `IOB_RST_WORD;
    w[N_CH-1:0] = v;
    return w;
  endfunction : iob_word

  // a bit moves only when stages 2 and 3 agree
  function automatic logic [N_CH-1:0] iob_accept(
    input logic [N_CH-1:0] s2,
    input logic [N_CH-1:0] s3,
    input logic [N_CH-1:0] a
  );
    return (s2 & s3) | (a & (s2 ^ s3));
  endfunction : iob_accept

  // ----------------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------------
  iob_flash #(
    .SLOT_MS (FLASH_MS)
  ) u_flash (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ms_tick  (st_q.ms_tick),
    .pat      (pat)
  );

  iob_debounce #(
    .N_CH (N_CH)
  ) u_deb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ms_tick  (st_q.ms_tick),
    .filt_ms  (st_q.filt),
    .raw      (st_q.in_a),
    .state    (in_deb)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [N_CH-1:0] live_flt;
    logic [N_CH-1:0] fclr;
    logic            sup_ok;
    logic            rng_ok;

    st_d     = st_q;
    live_flt = '0;
    fclr     = '0;

    // pin synchronisers; short enough for both hardware filter limits
    st_d.in_s1  = ch_in;
    st_d.in_s2  = st_q.in_s1;
    st_d.in_s3  = st_q.in_s2;
    st_d.in_a   = iob_accept(st_q.in_s2, st_q.in_s3, st_q.in_a);
    st_d.rng_s1 = ch_in_range_err;
    st_d.rng_s2 = st_q.rng_s1;
    st_d.rng_s3 = st_q.rng_s2;
    st_d.rng_a  = iob_accept(st_q.rng_s2, st_q.rng_s3, st_q.rng_a);
    st_d.oc_s1  = ch_overcurrent;
    st_d.oc_s2  = st_q.oc_s1;
    st_d.oc_s3  = st_q.oc_s2;
    st_d.oc_a   = iob_accept(st_q.oc_s2, st_q.oc_s3, st_q.oc_a);
    st_d.sup_s1 = {sup_in_range, sup_present};
    st_d.sup_s2 = st_q.sup_s1;
    st_d.sup_s3 = st_q.sup_s2;
    st_d.sup_a  = (st_q.sup_s2 & st_q.sup_s3)
                | (st_q.sup_a & (st_q.sup_s2 ^ st_q.sup_s3));
    sup_ok = st_q.sup_a[0];
    rng_ok = st_q.sup_a[1];

    // millisecond tick shared by debounce, re-arm and flash timing
    st_d.ms_tick = 1'b0;
    if (st_q.ms_cnt == 16'(MS_CYC - 1)) begin
      st_d.ms_cnt  = 16'h0000;
      st_d.ms_tick = 1'b1;
    end else begin
      st_d.ms_cnt = st_q.ms_cnt + 16'h0001;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (reg_req.wr) begin
      if (reg_req.addr == `IOB_A_CTRL) begin
        case (reg_req.wdata[1:0])
          IOB_BLK_PREOP: st_d.blk_st = IOB_BLK_PREOP;
          IOB_BLK_OPER:  st_d.blk_st = IOB_BLK_OPER;
          default:       st_d.blk_st = IOB_BLK_RESET;
        endcase
        st_d.blk_err = reg_req.wdata[`IOB_CTRL_ERR];
      end else if (reg_req.addr == `IOB_A_DIR) begin
        st_d.dir = reg_req.wdata[N_CH-1:0];
      end else if (reg_req.addr == `IOB_A_OUT) begin
        st_d.out_cmd = reg_req.wdata[N_CH-1:0];
      end else if (reg_req.addr == `IOB_A_FILT) begin
        // values above the longest filter time are held at it
        if (reg_req.wdata[4:0] > 5'(`IOB_FILT_MAX_MS)) begin
          st_d.filt = 5'(`IOB_FILT_MAX_MS);
        end else begin
          st_d.filt = reg_req.wdata[4:0];
        end
      end else if (reg_req.addr == `IOB_A_FAULT) begin
        fclr = reg_req.wdata[N_CH-1:0];
      end
    end

    // ----------------------------------------------------------------
    // output protection and automatic re-arm
    // ----------------------------------------------------------------
    for (int i = 0; i < N_CH; i++) begin
      if (!st_q.trip[i]) begin
        if (st_q.dir[i] && st_q.out_cmd[i] && st_q.oc_a[i]) begin
          st_d.trip[i] = 1'b1;
          st_d.rtmr[i] = 4'h0;
        end
      end else if (st_q.ms_tick) begin
        // one extra tick covers a partial first millisecond
        if (st_q.rtmr[i] == 4'(`IOB_REARM_MS)) begin
          st_d.trip[i] = 1'b0;
        end else begin
          st_d.rtmr[i] = st_q.rtmr[i] + 4'h1;
        end
      end
      live_flt[i] = st_q.dir[i] ? (st_q.oc_a[i] | st_q.trip[i]) : st_q.rng_a[i];
    end

    // sticky faults: a new fault wins over a clear in the same cycle
    st_d.fault = (st_q.fault & ~fclr) | live_flt;

    // outputs switch off while tripped or configured as input
    st_d.ch_out = st_q.dir & st_q.out_cmd & ~st_q.trip;

    // ----------------------------------------------------------------
    // indicators
    // ----------------------------------------------------------------
    // an output bit lit one cycle past a direction change still shows a driven pin
    st_d.led_ch = st_q.ch_out | (~st_q.dir & in_deb);

    // bus pair: off/off no power, on/on not initialised
    if (!bus_pwr) begin
      st_d.led.bus_grn = 1'b0;
      st_d.led.bus_red = 1'b0;
    end else if (bus_err) begin
      st_d.led.bus_grn = 1'b0;
      st_d.led.bus_red = 1'b1;
    end else if (st_q.blk_st == IOB_BLK_OPER) begin
      st_d.led.bus_grn = 1'b1;
      st_d.led.bus_red = 1'b0;
    end else begin
      st_d.led.bus_grn = 1'b1;
      st_d.led.bus_red = 1'b1;
    end

    // green block indicator
    if (!sup_ok) begin
      st_d.led.blk_grn = 1'b0;
    end else begin
      case (st_q.blk_st)
        IOB_BLK_PREOP: st_d.led.blk_grn = pat.blink;
        IOB_BLK_OPER:  st_d.led.blk_grn = 1'b1;
        default:       st_d.led.blk_grn = pat.single;
      endcase
    end

    // red block indicator, most serious condition first
    if (!sup_ok) begin
      st_d.led.blk_red = 1'b0;
    end else if (st_q.blk_err || st_q.blk_st == IOB_BLK_RESET) begin
      st_d.led.blk_red = 1'b1;
    end else if (!rng_ok) begin
      st_d.led.blk_red = pat.dbl;
    end else if (|live_flt) begin
      st_d.led.blk_red = pat.single;
    end else begin
      st_d.led.blk_red = 1'b0;
    end

    // ----------------------------------------------------------------
    // register reads: data stand for one cycle only
    // ----------------------------------------------------------------
    st_d.rdata = `IOB_RST_WORD;
    if (reg_req.rd) begin
      if (reg_req.addr == `IOB_A_ID) begin
        st_d.rdata = ID_CODE;
      end else if (reg_req.addr == `IOB_A_CTRL) begin
        st_d.rdata = {13'h0000, st_q.blk_err, st_q.blk_st};
      end else if (reg_req.addr == `IOB_A_DIR) begin
        st_d.rdata = iob_word(st_q.dir);
      end else if (reg_req.addr == `IOB_A_OUT) begin
        st_d.rdata = iob_word(st_q.out_cmd);
      end else if (reg_req.addr == `IOB_A_IN) begin
        st_d.rdata = iob_word(in_deb);
      end else if (reg_req.addr == `IOB_A_FILT) begin
        st_d.rdata = {11'h000, st_q.filt};
      end else if (reg_req.addr == `IOB_A_FAULT) begin
        st_d.rdata = iob_word(st_q.fault);
      end else if (reg_req.addr == `IOB_A_STAT) begin
        st_d.rdata = {10'h000, st_q.blk_st, bus_err, bus_pwr, rng_ok, sup_ok};
      end else if (reg_req.addr == `IOB_A_TRIP) begin
        st_d.rdata = iob_word(st_q.trip);
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= '0;
      st_q.blk_st <= IOB_BLK_RESET;
      st_q.filt   <= `IOB_RST_FILT;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign reg_rdata = st_q.rdata;
  assign ch_out    = st_q.ch_out;
  assign led       = st_q.led;
  assign led_ch    = st_q.led_ch;

endmodule : iob_top
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench of iob_top.
  Assumes iob_master as bus partner and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iob_map.svh"
// ----
// bench
// ----
module tb_top;
  import iob_pkg::*;
  localparam int MS    = 20;
  localparam int FRAME = 16 * MS;
  logic         core_clk = 1'b0;
  logic         rst_n;
  iob_reg_req_t reg_req;
  logic [15:0]  reg_rdata;
  logic         bus_pwr;
  logic         bus_err;
  logic         sup_present;
  logic         sup_in_range;
  logic [15:0]  ch_in;
  logic [15:0]  ch_in_range_err;
  logic [15:0]  ch_overcurrent;
  logic [15:0]  ch_out;
  iob_led_t     led;
  logic [15:0]  led_ch;
  int           bad_count = 0;
  int           n_compared = 0;
  int           r;
  int           h;
  // bus cases: power, error, green, red
  logic [3:0]   bt[4] = '{4'h0, 4'hD, 4'hA, 4'hB};
  // block cases: state, fault kind, led bit, rises and lit cycles per frame
  int           cs[8] = '{2, 1, 0, 0, 2, 2, 6, 2};
  int           fm[8] = '{0, 0, 0, 0, 1, 2, 0, 0};
  int           lb[8] = '{1, 1, 1, 0, 0, 0, 0, 0};
  int           tr[8] = '{0, 4, 1, 0, 2, 1, 0, 0};
  int           th[8] = '{FRAME, FRAME / 2, 2 * MS, FRAME, 4 * MS, 2 * MS, FRAME, 0};
  always #10 core_clk = ~core_clk;
  // identification value is arbitrary
  iob_top #(.MS_CYC(MS), .FLASH_MS(2), .ID_CODE(16'h3C96)) i_iob_top (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .bus_pwr(bus_pwr), .bus_err(bus_err), .sup_present(sup_present),
    .sup_in_range(sup_in_range), .ch_in(ch_in), .ch_in_range_err(ch_in_range_err),
    .ch_overcurrent(ch_overcurrent), .ch_out(ch_out), .led(led), .led_ch(led_ch));
  iob_master i_iob_master (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req),
    .bus_pwr(bus_pwr), .bus_err(bus_err));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_iob_master.rd(a, v);
    cmp(what, exp, v);
  endtask : rd_chk
  // one full frame, so every pattern shows whole
  task automatic flash(input int b, output int nr, output int nh);
    logic p;
    p  = led[b];
    nr = 0;
    nh = 0;
    repeat (FRAME) begin
      tick(1);
      nr += int'(led[b] && !p);
      nh += int'(led[b]);
      p  = led[b];
    end
  endtask : flash
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    rst_n           = 1'b0;
    sup_present     = 1'b0;
    sup_in_range    = 1'b0;
    ch_in           = 16'h0000;
    ch_in_range_err = 16'h0000;
    ch_overcurrent  = 16'h0000;
    repeat (6) @(posedge core_clk);
    rst_n        <= 1'b1;
    sup_present  <= 1'b1;
    sup_in_range <= 1'b1;
    rd_chk("id", `IOB_A_ID, 16'h3C96);
    i_iob_master.wr(`IOB_A_ID, 16'h0000);
    rd_chk("id kept", `IOB_A_ID, 16'h3C96);
    rd_chk("dir", `IOB_A_DIR, 16'h0000);
    rd_chk("unmapped", 4'hF, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      i_iob_master.wr(`IOB_A_CTRL, (i == 2) ? 16'h0002 : 16'h0001);
      i_iob_master.bus(bt[i][3], bt[i][2]);
      tick(3);
      cmp("bus", 16'(bt[i][1:0]), 16'({led.bus_grn, led.bus_red}));
    end
    $display("test bus leds done");
    i_iob_master.wr(`IOB_A_DIR, 16'h00FF);
    i_iob_master.wr(`IOB_A_OUT, 16'h00A5);
    @(posedge core_clk);
    ch_in <= 16'h5A00;
    tick(10);
    cmp("ch_out", 16'h00A5, ch_out);
    cmp("led_ch", 16'h5AA5, led_ch);
    rd_chk("inputs", `IOB_A_IN, 16'h5A00);
    i_iob_master.wr(`IOB_A_FILT, 16'h001F);
    rd_chk("filter max", `IOB_A_FILT, 16'h0019);
    i_iob_master.wr(`IOB_A_FILT, 16'h0002);
    @(posedge core_clk);
    ch_in <= 16'h5B00;
    tick(15);
    cmp("led_ch filtered", 16'h5AA5, led_ch);
    tick(45);
    cmp("led_ch accepted", 16'h5BA5, led_ch);
    $display("test channels done");
    for (int i = 0; i < 8; i++) begin
      i_iob_master.wr(`IOB_A_CTRL, 16'(cs[i]));
      @(posedge core_clk);
      sup_in_range    <= (fm[i] != 1);
      ch_in_range_err <= (fm[i] == 2) ? 16'h0100 : 16'h0000;
      tick(10);
      flash(lb[i], r, h);
      cmp("flashes", 16'(tr[i]), 16'(r));
      cmp("lit", 16'(th[i]), 16'(h));
    end
    $display("test block leds done");
    // the input range error of channel 8 is still latched; supply loss darkens both
    rd_chk("fault", `IOB_A_FAULT, 16'h0100);
    i_iob_master.wr(`IOB_A_FAULT, 16'hFFFF);
    rd_chk("fault cleared", `IOB_A_FAULT, 16'h0000);
    @(posedge core_clk);
    sup_present <= 1'b0;
    tick(12);
    cmp("unpowered", 16'h0000, 16'({led.blk_grn, led.blk_red}));
    rd_chk("status", `IOB_A_STAT, 16'h0026);
    @(posedge core_clk);
    sup_present <= 1'b1;
    tick(10);
    $display("test supply done");
    @(posedge core_clk);
    ch_overcurrent <= 16'h0001;
    tick(10);
    cmp("ch_out tripped", 16'h00A4, ch_out);
    rd_chk("trip", `IOB_A_TRIP, 16'h0001);
    tick(8 * MS);
    cmp("ch_out held", 16'h00A4, ch_out);
    r = 0;
    while (ch_out[0] !== 1'b1 && r < 4 * MS) begin
      tick(1);
      r++;
    end
    // a wait that runs out fails here and still ends in the closing report
    cmp("ch_out re-armed", 16'h00A5, ch_out);
    @(posedge core_clk);
    ch_overcurrent <= 16'h0000;
    $display("test re-arm done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
